// ==== hw/cmd_decoder.sv ====
// Eight-byte command decoder: collects a command, applies it, answers.
// What this block does
// - Each response echoes the received opcode in byte 3 and, for the register commands, the code byte.
// - Response bytes 4 and 5 hold the drive status word, high byte first.
// - Every operand is signed two's complement and is applied as such.
// - The operand sits in command bytes 4 to 7, big-endian, right-aligned.
// - Response byte 1 reports axis zero and message type one.
// - Response byte 2 echoes the code only for the four register commands.
// - Opcode 1E sets the acceleration rate in units of 10 rpm per second.
// - Opcode 1F sets the deceleration rate in units of 10 rpm per second.
// - Opcode 1D sets the move velocity in units of 0.25 rpm.
// - Opcode B6 sets the move distance in steps, using all four bytes.
// - Opcode 66 starts a feed-to-length move with the stored settings.
// - Every command gets a response, even when nothing is read back.
// - Immediate-class commands are not accepted in this message type.
module cmd_decoder (
  input  wire logic        clk_sys,       // System clock, 125 MHz.
  input  wire logic        rst,           // Synchronous reset, active high.
  input  wire logic        ce,            // Clock enable; low freezes state.
  input  wire logic        cmd_valid,     // Command byte offered.
  input  wire logic [7:0]  cmd_byte,      // Command byte, byte 0 first.
  output logic             cmd_ready,     // Decoder takes a command byte.
  output logic             rsp_valid,     // Response byte offered.
  output logic      [7:0]  rsp_byte,      // Response byte, byte 0 first.
  input  wire logic        rsp_ready,     // Partner takes a response byte.
  input  wire logic [15:0] drive_status,  // Live drive status word.
  output logic      [31:0] accel_rate,    // Signed, 10 rpm/s units.
  output logic      [31:0] decel_rate,    // Signed, 10 rpm/s units.
  output logic      [31:0] move_velocity, // Signed, 0.25 rpm units.
  output logic      [31:0] move_distance, // Signed, motor steps.
  output logic             move_start,    // One-cycle feed-to-length start.
  output logic             cmd_rejected   // One-cycle pulse, command ignored.
);

  typedef struct packed {
    cmd_decoder_pkg::phase_e phase;
    cmd_decoder_pkg::idx_t   idx;
    logic [7:0][7:0]         cmd;
    logic [15:0]             status;
    logic signed [31:0]      accel;
    logic signed [31:0]      decel;
    logic signed [31:0]      velocity;
    logic signed [31:0]      distance;
    logic                    cmd_ready;
    logic                    rsp_valid;
    logic [7:0]              rsp_byte;
    logic                    move_start;
    logic                    rejected;
  } state_s;

  localparam state_s STATE_RESET = '{
    phase:      cmd_decoder_pkg::ST_RECV,
    idx:        3'h0,
    cmd:        64'h0,
    status:     cmd_decoder_pkg::STATUS_RESET,
    accel:      cmd_decoder_pkg::SETTING_RESET,
    decel:      cmd_decoder_pkg::SETTING_RESET,
    velocity:   cmd_decoder_pkg::SETTING_RESET,
    distance:   cmd_decoder_pkg::SETTING_RESET,
    cmd_ready:  1'b1,
    rsp_valid:  1'b0,
    rsp_byte:   8'h00,
    move_start: 1'b0,
    rejected:   1'b0
  };

  // The operand is read as one signed word, so short operands that the
  // sender right-aligns with zero upper bytes come out unchanged only if non-negative.
  // big-endian operand bytes
  function automatic logic signed [31:0] operand_of(
    input logic [7:0][7:0] c
  );
    return signed'({c[cmd_decoder_pkg::OPERAND_B0_IDX],
                    c[cmd_decoder_pkg::OPERAND_B1_IDX],
                    c[cmd_decoder_pkg::OPERAND_B2_IDX],
                    c[cmd_decoder_pkg::OPERAND_B3_IDX]});
  endfunction : operand_of

  function automatic logic is_register_op(input logic [7:0] op);
    return (op == cmd_decoder_pkg::OP_QUEUE_REGISTER_READ) ||
           (op == cmd_decoder_pkg::OP_REGISTER_READ) ||
           (op == cmd_decoder_pkg::OP_REGISTER_WRITE) ||
           (op == cmd_decoder_pkg::OP_REGISTER_EXCHANGE);
  endfunction : is_register_op

  state_s            r;
  state_s            d;
  logic [7:0]        opcode;
  logic              echo_reg;
  logic              header_ok;
  logic              immediate;
  cmd_decoder_pkg::idx_t sel_idx;
  logic [7:0]        sel_byte;

  assign opcode   = r.cmd[cmd_decoder_pkg::OPCODE_IDX];
  assign echo_reg = is_register_op(opcode);
  assign header_ok =
    (r.cmd[cmd_decoder_pkg::RESERVED_IDX] == cmd_decoder_pkg::BYTE_ZERO) &&
    ((r.cmd[cmd_decoder_pkg::AXIS_IDX] == cmd_decoder_pkg::AXIS_ZERO) ||
     (r.cmd[cmd_decoder_pkg::AXIS_IDX] == cmd_decoder_pkg::MSG_TYPE_ONE));
  assign immediate = opcode >= cmd_decoder_pkg::OP_IMMEDIATE_FIRST;

  // In the execute cycle the mux yields byte 0, later the byte after idx.
  assign sel_idx = (r.phase == cmd_decoder_pkg::ST_SEND) ?
                   r.idx + 3'h1 : cmd_decoder_pkg::RESERVED_IDX;

  rsp_byte_select u_rsp_byte_select (
    .idx      (sel_idx),
    .opcode   (opcode),
    .reg_code (r.cmd[cmd_decoder_pkg::CODE_IDX]),
    .echo_reg (echo_reg),
    .status   (r.status),
    .rsp_byte (sel_byte)
  );

  always_comb begin
    d            = r;
    d.move_start = 1'b0;
    d.rejected   = 1'b0;
    case (r.phase)
      cmd_decoder_pkg::ST_RECV: begin
        if (cmd_valid && r.cmd_ready) begin
          d.cmd[r.idx] = cmd_byte;
          d.idx        = r.idx + 3'h1;
          if (r.idx == cmd_decoder_pkg::LAST_IDX) begin
            d.cmd_ready = 1'b0;
            d.phase     = cmd_decoder_pkg::ST_EXEC;
          end
        end
      end
      cmd_decoder_pkg::ST_EXEC: begin
        // Status is latched first so the mux sees it from the next byte on.
        d.status = drive_status;
        if (!header_ok || immediate) begin
          d.rejected = 1'b1;
        end else begin
          case (opcode)
            cmd_decoder_pkg::OP_SET_ACCEL_RATE:
              d.accel = operand_of(r.cmd);
            cmd_decoder_pkg::OP_SET_DECEL_RATE:
              d.decel = operand_of(r.cmd);
            cmd_decoder_pkg::OP_SET_MOVE_VELOCITY:
              d.velocity = operand_of(r.cmd);
            cmd_decoder_pkg::OP_SET_MOVE_DISTANCE:
              d.distance = operand_of(r.cmd);
            cmd_decoder_pkg::OP_START_FEED_LENGTH_MOVE:
              d.move_start = 1'b1;
            default:
              d.move_start = 1'b0;
          endcase
        end
        d.rsp_valid = 1'b1;
        d.rsp_byte  = sel_byte;
        d.idx       = cmd_decoder_pkg::RESERVED_IDX;
        d.phase     = cmd_decoder_pkg::ST_SEND;
      end
      cmd_decoder_pkg::ST_SEND: begin
        if (rsp_ready && r.rsp_valid) begin
          if (r.idx == cmd_decoder_pkg::LAST_IDX) begin
            d.rsp_valid = 1'b0;
            d.cmd_ready = 1'b1;
            d.idx       = 3'h0;
            d.phase     = cmd_decoder_pkg::ST_RECV;
          end else begin
            d.idx      = r.idx + 3'h1;
            d.rsp_byte = sel_byte;
          end
        end
      end
      default: begin
        d = STATE_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r <= STATE_RESET;
    end else if (ce) begin
      r <= d;
    end
  end

  assign cmd_ready     = r.cmd_ready;
  assign rsp_valid     = r.rsp_valid;
  assign rsp_byte      = r.rsp_byte;
  assign accel_rate    = r.accel;
  assign decel_rate    = r.decel;
  assign move_velocity = r.velocity;
  assign move_distance = r.distance;
  assign move_start    = r.move_start;
  assign cmd_rejected  = r.rejected;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic exec_ok;
  assign exec_ok = (r.phase == cmd_decoder_pkg::ST_EXEC) && ce &&
                   header_ok && !immediate;

  AST_OPCODE_ECHO: assert property (
    rsp_valid && r.idx == cmd_decoder_pkg::OPCODE_IDX |->
      rsp_byte == r.cmd[cmd_decoder_pkg::OPCODE_IDX])
    else $error("Response byte 3 differs from the opcode.");

  AST_STATUS_WORD: assert property (
    rsp_valid && r.idx == cmd_decoder_pkg::STATUS_MSB_IDX && rsp_ready && ce
      |=> rsp_byte == r.status[7:0] && $past(rsp_byte) == r.status[15:8])
    else $error("Status word bytes are wrong or out of order.");

  AST_OPERAND_SIGNED: assert property (
    exec_ok && opcode == cmd_decoder_pkg::OP_SET_ACCEL_RATE |=>
      accel_rate == {r.cmd[cmd_decoder_pkg::OPERAND_B0_IDX],
                     r.cmd[cmd_decoder_pkg::OPERAND_B1_IDX],
                     r.cmd[cmd_decoder_pkg::OPERAND_B2_IDX],
                     r.cmd[cmd_decoder_pkg::OPERAND_B3_IDX]})
    else $error("Acceleration rate was not taken from the operand.");

  AST_DISTANCE_FULL: assert property (
    exec_ok && opcode == cmd_decoder_pkg::OP_SET_MOVE_DISTANCE |=>
      move_distance == {r.cmd[cmd_decoder_pkg::OPERAND_B0_IDX],
                        r.cmd[cmd_decoder_pkg::OPERAND_B1_IDX],
                        r.cmd[cmd_decoder_pkg::OPERAND_B2_IDX],
                        r.cmd[cmd_decoder_pkg::OPERAND_B3_IDX]})
    else $error("Move distance does not match command bytes 4 to 7.");

  AST_AXIS_TYPE: assert property (
    rsp_valid && r.idx == cmd_decoder_pkg::AXIS_IDX |->
      rsp_byte == cmd_decoder_pkg::RSP_AXIS_TYPE)
    else $error("Response byte 1 is not axis zero, type one.");

  AST_CODE_ECHO: assert property (
    rsp_valid && r.idx == cmd_decoder_pkg::CODE_IDX |->
      rsp_byte == (echo_reg ? r.cmd[cmd_decoder_pkg::CODE_IDX] : 8'h00))
    else $error("Response byte 2 is wrong for this opcode.");

  AST_ZERO_BYTES: assert property (
    rsp_valid && (r.idx == cmd_decoder_pkg::RESERVED_IDX ||
                  r.idx == cmd_decoder_pkg::OPERAND_B2_IDX ||
                  r.idx == cmd_decoder_pkg::LAST_IDX) |->
      rsp_byte == cmd_decoder_pkg::BYTE_ZERO)
    else $error("A reserved response byte is not zero.");

  AST_MOVE_START: assert property (
    // A pulse held by a low enable is judged only where it was launched.
    move_start && $past(ce) |-> $past(exec_ok) &&
      $past(opcode) == cmd_decoder_pkg::OP_START_FEED_LENGTH_MOVE)
    else $error("Move start without a feed-to-length command.");

  AST_ALWAYS_ANSWER: assert property (
    r.phase == cmd_decoder_pkg::ST_EXEC && ce |=>
      rsp_valid && !cmd_ready && rsp_byte == 8'h00)
    else $error("A command was not answered.");

  AST_IMMEDIATE_IGNORED: assert property (
    r.phase == cmd_decoder_pkg::ST_EXEC && ce && immediate |=>
      cmd_rejected && !move_start && $stable(accel_rate) &&
      $stable(move_distance))
    else $error("An immediate-class command was applied.");

  AST_ONE_AT_A_TIME: assert property (
    !(cmd_ready && rsp_valid))
    else $error("Command taken while a response is pending.");

  COV_ACCEL_SET: cover property (
    exec_ok && opcode == cmd_decoder_pkg::OP_SET_ACCEL_RATE);
  COV_FEED_START: cover property (move_start);
  COV_REJECT: cover property (cmd_rejected);
  COV_RSP_STALL: cover property (rsp_valid && !rsp_ready ##1 rsp_valid);

endmodule : cmd_decoder

// ==== hw/cmd_decoder_pkg.sv ====
// Shared constants and types of the eight-byte command decoder.
package cmd_decoder_pkg;

  typedef logic [2:0] idx_t;

  // Message layout, as byte positions inside an eight-byte message.
  localparam idx_t RESERVED_IDX    = 3'h0;
  localparam idx_t AXIS_IDX        = 3'h1;
  localparam idx_t CODE_IDX        = 3'h2;
  localparam idx_t OPCODE_IDX      = 3'h3;
  localparam idx_t OPERAND_B0_IDX  = 3'h4;
  localparam idx_t OPERAND_B1_IDX  = 3'h5;
  localparam idx_t OPERAND_B2_IDX  = 3'h6;
  localparam idx_t OPERAND_B3_IDX  = 3'h7;
  localparam idx_t STATUS_MSB_IDX  = 3'h4;
  localparam idx_t STATUS_LSB_IDX  = 3'h5;
  localparam idx_t LAST_IDX        = 3'h7;

  // Header values.
  localparam logic [7:0] BYTE_ZERO      = 8'h00;
  localparam logic [7:0] AXIS_ZERO      = 8'h00;
  localparam logic [7:0] MSG_TYPE_ONE   = 8'h01;
  // Response byte 1: axis zero in the upper nibble, message type one below.
  localparam logic [7:0] RSP_AXIS_TYPE  = 8'h01;

  // Opcodes of the buffered command set handled here.
  localparam logic [7:0] OP_SET_MOVE_VELOCITY      = 8'h1D;
  localparam logic [7:0] OP_SET_ACCEL_RATE         = 8'h1E;
  localparam logic [7:0] OP_SET_DECEL_RATE         = 8'h1F;
  localparam logic [7:0] OP_START_FEED_LENGTH_MOVE = 8'h66;
  localparam logic [7:0] OP_SET_MOVE_DISTANCE      = 8'hB6;

  // Register opcodes whose code byte is echoed; values are arbitrary.
  localparam logic [7:0] OP_QUEUE_REGISTER_READ    = 8'hF0;
  localparam logic [7:0] OP_REGISTER_READ          = 8'hF1;
  localparam logic [7:0] OP_REGISTER_WRITE         = 8'hF2;
  localparam logic [7:0] OP_REGISTER_EXCHANGE      = 8'hF3;
  // Opcodes at or above this one are the immediate class; value arbitrary.
  localparam logic [7:0] OP_IMMEDIATE_FIRST        = 8'hF8;

  localparam logic signed [31:0] SETTING_RESET = 32'sh0000_0000;
  localparam logic [15:0]        STATUS_RESET  = 16'h0000;

  typedef enum logic [2:0] {
    ST_RECV = 3'h1,
    ST_EXEC = 3'h2,
    ST_SEND = 3'h4
  } phase_e;

endpackage : cmd_decoder_pkg

// ==== hw/rsp_byte_select.sv ====
// Selects one byte of the eight-byte response message.
module rsp_byte_select (
  input  wire logic [2:0]  idx,       // Response byte position.
  input  wire logic [7:0]  opcode,    // Opcode taken from the command.
  input  wire logic [7:0]  reg_code,  // Code byte taken from the command.
  input  wire logic        echo_reg,  // High for the register commands.
  input  wire logic [15:0] status,    // Latched drive status word.
  output logic      [7:0]  rsp_byte   // Byte at position idx.
);

  always_comb begin
    case (idx)
      cmd_decoder_pkg::AXIS_IDX:
        rsp_byte = cmd_decoder_pkg::RSP_AXIS_TYPE;
      cmd_decoder_pkg::CODE_IDX:
        rsp_byte = echo_reg ? reg_code : cmd_decoder_pkg::BYTE_ZERO;
      cmd_decoder_pkg::OPCODE_IDX:
        rsp_byte = opcode;
      cmd_decoder_pkg::STATUS_MSB_IDX:
        rsp_byte = status[15:8];
      cmd_decoder_pkg::STATUS_LSB_IDX:
        rsp_byte = status[7:0];
      default:
        rsp_byte = cmd_decoder_pkg::BYTE_ZERO;
    endcase
  end

endmodule : rsp_byte_select

// ==== testbench/net_ctrl_model.sv ====
// Behavioural network controller that talks to the command decoder.
module net_ctrl_model (
  input  wire logic        clk_sys,   // System clock.
  input  wire logic        rst,       // Synchronous reset, active high.
  input  wire logic        ce,        // Decoder clock enable.
  input  wire logic        slow,      // High to stall at random.
  input  wire logic        cmd_ready, // Decoder takes a byte.
  output logic             cmd_valid, // Command byte offered.
  output logic      [7:0]  cmd_byte,  // Command byte.
  input  wire logic        rsp_valid, // Response byte offered.
  input  wire logic [7:0]  rsp_byte,  // Response byte.
  output logic             rsp_ready, // Response byte accepted.
  output logic      [63:0] rsp_msg,   // Last whole response, byte 0 on top.
  output logic             rsp_done,  // One cycle per whole response.
  output logic             stuck      // A command byte was never taken.
);
  timeunit 1ns;
  timeprecision 1ps;

  integer     seed = 32'h5CE35873;
  logic [2:0] rsp_cnt_q = 3'h0;

  initial begin
    cmd_valid = 1'b0;
    cmd_byte  = 8'hA5;
    rsp_ready = 1'b0;
    rsp_msg   = 64'h0;
    rsp_done  = 1'b0;
    stuck     = 1'b0;
  end

  task automatic send_cmd(input logic [63:0] msg);
    int n;
    @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      // An idle line shows the inverse of what it last held; before byte 0 that restores the previous command's last byte.
      if (slow && ($random(seed) & 3) == 0) begin
        cmd_valid <= 1'b0;
        cmd_byte  <= ~cmd_byte;
        @(posedge clk_sys);
      end
      cmd_valid <= 1'b1;
      cmd_byte  <= msg[63 - 8 * i -: 8];
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (!(cmd_ready && ce) && n < 300);
      if (n >= 300)
        stuck <= 1'b1;
    end
    cmd_valid <= 1'b0;
    cmd_byte  <= ~msg[7:0];
  endtask : send_cmd

  always @(posedge clk_sys) begin
    rsp_done  <= 1'b0;
    rsp_ready <= !slow || (($random(seed) & 1) == 1);
    if (rst)
      rsp_cnt_q <= 3'h0;
    else if (rsp_valid && rsp_ready && ce) begin
      rsp_msg   <= {rsp_msg[55:0], rsp_byte};
      rsp_cnt_q <= rsp_cnt_q + 3'h1;
      rsp_done  <= (rsp_cnt_q == 3'h7);
    end
  end
endmodule : net_ctrl_model

// ==== testbench/eight_byte_command_decoder_test.sv ====
// Self-checking bench of the eight-byte command decoder.
module eight_byte_command_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys, rst, ce, ce_rand, slow;
  logic        cmd_valid, cmd_ready, rsp_valid, rsp_ready;
  logic [7:0]  cmd_byte, rsp_byte;
  logic [15:0] drive_status;
  logic [31:0] accel_rate, decel_rate, move_velocity, move_distance;
  logic        move_start, cmd_rejected, rsp_done, stuck;
  logic [63:0] rsp_msg;
  logic [63:0] expect_q[$];
  logic [31:0] acc_m, dec_m, vel_m, dist_m;
  logic [7:0]  ops[8];
  integer      seed = 32'h5CE35873;
  int          failures = 0;
  int          tests_run = 0;
  int          starts = 0, starts_m = 0, rejects = 0, rejects_m = 0;

  cmd_decoder dut (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_byte(rsp_byte), .rsp_ready(rsp_ready), .drive_status(drive_status),
    .accel_rate(accel_rate), .decel_rate(decel_rate),
    .move_velocity(move_velocity), .move_distance(move_distance),
    .move_start(move_start), .cmd_rejected(cmd_rejected));

  net_ctrl_model ctrl (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .slow(slow),
    .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .rsp_ready(rsp_ready),
    .rsp_msg(rsp_msg), .rsp_done(rsp_done), .stuck(stuck));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  // A held pulse is counted once, at the first enabled edge that sees it.
  always @(posedge clk_sys) begin
    ce <= !ce_rand || (($random(seed) & 3) != 0);
    if (ce && move_start)
      starts++;
    if (ce && cmd_rejected)
      rejects++;
  end

  always @(posedge clk_sys) begin
    logic [63:0] exp_msg;
    exp_msg = 64'h0;
    if (rsp_done && expect_q.size() == 0) begin
      failures++;
      $display("BAD response expected none seen %h", rsp_msg);
    end else if (rsp_done) begin
      exp_msg = expect_q.pop_front();
      check("response", rsp_msg, exp_msg);
    end
  end

  task automatic run_cmd(input logic [7:0] b0, b1, code, op,
                         input logic [31:0] arg, input logic hold);
    logic rej;
    int   n;
    ctrl.send_cmd({b0, b1, code, op, arg});
    rej = b0 != 8'h00 || b1 > 8'h01
          || op >= cmd_decoder_pkg::OP_IMMEDIATE_FIRST;
    expect_q.push_back({8'h00, 8'h01,
      (op >= cmd_decoder_pkg::OP_QUEUE_REGISTER_READ
       && op <= cmd_decoder_pkg::OP_REGISTER_EXCHANGE) ? code : 8'h00,
      op, drive_status, 16'h0000});
    if (rej)
      rejects_m++;
    else case (op)
      8'h1E: acc_m = arg;
      8'h1F: dec_m = arg;
      8'h1D: vel_m = arg;
      8'hB6: dist_m = arg;
      8'h66: starts_m++;
      default: ;
    endcase
    if (!hold)
      return;
    n = 0;
    while (expect_q.size() != 0 && n < 400 && stuck !== 1'b1) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 400 || stuck !== 1'b0) begin
      failures++;
      $display("BAD response_wait expected %0d seen %0d", 0, expect_q.size());
      test_done();
    end
    // Settled outputs are read here, away from the launching edge.
    check("accel_rate", accel_rate, acc_m);
    check("decel_rate", decel_rate, dec_m);
    check("move_velocity", move_velocity, vel_m);
    check("move_distance", move_distance, dist_m);
    check("starts", 64'(starts), 64'(starts_m));
    check("rejects", 64'(rejects), 64'(rejects_m));
    @(posedge clk_sys);
    drive_status <= 16'($random(seed));
  endtask : run_cmd

  initial begin
    logic [7:0] op;
    rst = 1'b1;
    ce = 1'b1;
    ce_rand = 1'b0;
    slow = 1'b0;
    drive_status = 16'hC35A;
    {acc_m, dec_m, vel_m, dist_m} = '0;
    ops = '{8'h1D, 8'h1E, 8'h1F, 8'h66, 8'hB6, 8'hF1, 8'h2A, 8'hF3};
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    run_cmd(8'h00, 8'h01, 8'h00, 8'h1E, 32'h0000_0258, 1'b1);
    run_cmd(8'h00, 8'h01, 8'h00, 8'h1F, 32'h0000_0384, 1'b1);
    run_cmd(8'h00, 8'h01, 8'h00, 8'h1D, 32'h0000_04B0, 1'b1);
    run_cmd(8'h00, 8'h01, 8'h00, 8'hB6, 32'h0001_86A0, 1'b1);
    run_cmd(8'h00, 8'h01, 8'h00, 8'h66, 32'h0000_0000, 1'b1);
    run_cmd(8'h00, 8'h00, 8'h00, 8'hB6, 32'hFFFF_FF9C, 1'b1);
    for (int i = 0; i < 4; i++)
      run_cmd(8'h00, 8'h01, 8'h40 + 8'(i), 8'hF0 + 8'(i), 32'h0, 1'b1);
    // Malformed or immediate commands still get an answer.
    run_cmd(8'h01, 8'h01, 8'h00, 8'h1E, 32'h0000_1111, 1'b1);
    run_cmd(8'h00, 8'h02, 8'h00, 8'h1F, 32'h0000_2222, 1'b1);
    run_cmd(8'h00, 8'h01, 8'h00, 8'hF8, 32'h0000_3333, 1'b1);
    run_cmd(8'h00, 8'h01, 8'h00, 8'hFF, 32'h0000_4444, 1'b1);
    slow <= 1'b1;
    ce_rand <= 1'b1;
    // Back-to-back commands offer bytes while the decoder is still busy.
    for (int i = 0; i < 40; i++) begin
      op = ops[$random(seed) & 7];
      run_cmd(8'h00, 8'h01, (op >= 8'hF0) ? 8'($random(seed)) : 8'h00, op,
              32'($random(seed)), i == 39);
    end
    test_done();
  end
endmodule : eight_byte_command_decoder_test
